//--- rtl/strap_pkg.sv
// Purpose: Shared constants and types for the strap option capture block.
// Assumes: One 50 MHz clock, synchronous active-low reset.
// Notes: Register indices sit behind the index/data port pair.
package strap_pkg;

    // Port pair addresses on the I/O space.
    localparam logic [15:0] INDEX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;

    // Register indices.
    localparam logic [7:0] IDX_BANK_ZERO = 8'h4A;
    localparam logic [7:0] IDX_BANK_ONE = 8'h4B;
    localparam logic [7:0] IDX_BANK_TWO = 8'h4C;
    localparam logic [7:0] IDX_HOST_PLL = 8'h5F;

    // Strap pin positions on the memory data bus.
    localparam int PIN_PLL_LO = 6;
    localparam int PIN_PLL_HI = 7;
    localparam int PIN_BUS_LO = 8;
    localparam int PIN_BUS_HI = 9;
    localparam int PIN_SYNC = 5;
    localparam int PIN_DIV_HI = 4;
    localparam int PIN_DIV_LO = 17;
    localparam int PIN_MULT_LO = 14;
    localparam int PIN_MULT_HI = 40;
    localparam int PIN_BOOT = 36;
    localparam int PIN_HOST_DIR = 18;
    localparam int PIN_MEM_DIR = 19;
    localparam int PIN_DOT_DIR = 20;
    localparam int PIN_SPD0 = 24;
    localparam int PIN_SPD1 = 25;
    localparam int PIN_SPD2 = 26;
    localparam int PIN_SECOND_SERIAL_PORT = 50;
    localparam int PIN_FIRST_SERIAL_PORT = 51;
    localparam int PIN_KBD = 52;
    localparam int PIN_PAR = 53;

    // Field positions inside bank two.
    localparam int B2_DOT_DIR = 4;

    // Values after reset of the captured registers.
    localparam logic [7:0] RESET_BANK = 8'h00;

    // Cycles after reset release at which the pins are sampled.
    localparam logic [3:0] SAMPLE_DELAY = 4'h4;

    // Expansion bus modes.
    typedef enum logic [1:0] {
        BUS_ISA = 2'h0,
        BUS_PCMCIA = 2'h1,
        BUS_LOCAL = 2'h2,
        BUS_NONE = 2'h3
    } bus_mode_t;

    // Divide ratio of the PCI clock output from the host clock.
    function automatic logic [2:0] pciDivisor(input logic [1:0] sel);
        logic [2:0] r;
        r = 3'h4;
        if (sel[1]) begin
            r = sel[0] ? 3'h2 : 3'h3;
        end
        return r;
    endfunction : pciDivisor

endpackage : strap_pkg

//--- rtl/strap_if.sv
// Purpose: Carries captured strap settings from the capture core to the top.
// Assumes: Single clock domain.
// Notes: Core drives the settings, top drives the dot direction write.
`timescale 1ns/10ps
`default_nettype none
interface strap_if;
    logic [7:0] bankZero;
    logic [7:0] bankOne;
    logic [7:0] bankTwo;
    logic [7:0] hostPll;
    logic [3:0] hwStraps;
    logic captured;
    logic dotDirWr;
    logic dotDirVal;
    modport core (
        output bankZero, bankOne, bankTwo, hostPll, hwStraps, captured,
        input dotDirWr, dotDirVal
    );
    modport user (
        input bankZero, bankOne, bankTwo, hostPll, hwStraps, captured,
        output dotDirWr, dotDirVal
    );
endinterface : strap_if
`default_nettype wire

//--- rtl/strap_sampler.sv
// Purpose: Synchronises strap pins and latches them once after reset.
// Assumes: Pins are stable during the sampling delay.
// Notes: Only the dot clock direction bit may change afterwards.
`timescale 1ns/10ps
`default_nettype none
module strap_sampler (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Strap pins
    input wire logic [63:0] memoryDataStrapPins,
    input wire logic terminalCountStrap,
    input wire logic [2:0] encodedDmaAckStrap,
    // Captured settings
    strap_if.core st
);
    logic [63:0] mdMeta_q;
    logic [63:0] mdSync_q;
    logic [3:0] hwMeta_q;
    logic [3:0] hwSync_q;
    logic [3:0] delay_q;
    logic done_q;
    logic [7:0] b0_q, b1_q, b2_q, b5_q;
    logic [3:0] hw_q;

    always_ff @(posedge mclk) begin
        mdMeta_q <= memoryDataStrapPins;
        mdSync_q <= mdMeta_q;
        hwMeta_q <= {terminalCountStrap, encodedDmaAckStrap};
        hwSync_q <= hwMeta_q;
    end

    // Single capture point after reset release.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            delay_q <= 4'h0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            if (delay_q == strap_pkg::SAMPLE_DELAY) begin
                done_q <= 1'b1; // see (RQ1)
            end else begin
                delay_q <= delay_q + 4'h1;
            end
        end
    end

    wire logic captureNow = !done_q && (delay_q == strap_pkg::SAMPLE_DELAY);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            b0_q <= strap_pkg::RESET_BANK;
            b1_q <= strap_pkg::RESET_BANK;
            b2_q <= strap_pkg::RESET_BANK;
            b5_q <= strap_pkg::RESET_BANK;
            hw_q <= 4'h0;
        end else if (captureNow) begin
            // Reserved positions are forced to zero.
            b0_q <= {mdSync_q[strap_pkg::PIN_PLL_HI], mdSync_q[strap_pkg::PIN_PLL_LO],
                     mdSync_q[strap_pkg::PIN_BUS_HI], mdSync_q[strap_pkg::PIN_BUS_LO],
                     1'b0, mdSync_q[strap_pkg::PIN_SYNC],
                     mdSync_q[strap_pkg::PIN_DIV_HI], mdSync_q[strap_pkg::PIN_DIV_LO]};
            b1_q <= {mdSync_q[strap_pkg::PIN_MULT_HI], mdSync_q[strap_pkg::PIN_MULT_LO],
                     5'h00, mdSync_q[strap_pkg::PIN_BOOT]}; // see (RQ7) (RQ16)
            b2_q <= {mdSync_q[strap_pkg::PIN_PAR], mdSync_q[strap_pkg::PIN_KBD], 1'b0,
                     mdSync_q[strap_pkg::PIN_DOT_DIR], mdSync_q[strap_pkg::PIN_MEM_DIR],
                     mdSync_q[strap_pkg::PIN_HOST_DIR],
                     mdSync_q[strap_pkg::PIN_FIRST_SERIAL_PORT], mdSync_q[strap_pkg::PIN_SECOND_SERIAL_PORT]};
            b5_q <= {2'h0, mdSync_q[strap_pkg::PIN_SPD2], mdSync_q[strap_pkg::PIN_SPD1],
                     mdSync_q[strap_pkg::PIN_SPD0], 3'h0};
            hw_q <= hwSync_q; // see (RQ12)
        end else if (done_q && st.dotDirWr) begin
            b2_q[strap_pkg::B2_DOT_DIR] <= st.dotDirVal; // see (RQ15)
        end
    end

    assign st.bankZero = b0_q;
    assign st.bankOne = b1_q;
    assign st.bankTwo = b2_q;
    assign st.hostPll = b5_q;
    assign st.hwStraps = hw_q;
    assign st.captured = done_q;

    property p_frozen;
        @(posedge mclk) disable iff (!reset_n)
        $past(done_q) && done_q |-> $stable(b0_q) && $stable(b1_q) && $stable(b5_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("Bank changed after capture."); // see (RQ16)

    property p_once;
        @(posedge mclk) disable iff (!reset_n)
        $rose(done_q) |=> done_q [*8];
    endproperty
    a_once: assert property (p_once) else $error("Capture flag dropped."); // see (RQ1)
endmodule : strap_sampler
`default_nettype wire

//--- rtl/strap_option_capture.sv
// Purpose: Strap option capture and decode with index/data register access.
// Assumes: Pins held by pull resistors; one 50 MHz clock.
// Notes: Clock controls stay parked until the straps are captured.
// Behaviour
// (RQ1) Latch straps once, keep them afterwards.
// (RQ2) Bank zero at 4Ah is read-only.
// (RQ3) Bits 7-6: PCI PLL range select.
// (RQ4) Bits 5-4: one expansion bus enabled.
// (RQ5) Bit 2: memory/host clock synchronisation.
// (RQ6) Bits 1-0: PCI clock divisor.
// (RQ7) 4Bh bit 0: boot device width.
// (RQ8) 4Ch bit 0: second serial port enable.
// (RQ9) 4Ch bit 1: first serial port enable.
// (RQ10) 4Ch bit 6: keyboard/mouse enable.
// (RQ11) 4Ch bit 7: parallel port enable.
// (RQ12) Terminal count and DMA ack straps sampled.
// (RQ13) Host clock pad: input or driven.
// (RQ14) Memory clock output: tristated or driven.
// (RQ15) 4Ch read-only except writable bit 4.
// (RQ16) Reserved bits zero; values held until reset.
// (RQ17) Clock settings applied only after capture.
`timescale 1ns/10ps
`default_nettype none
module strap_option_capture (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Strap pins
    input wire logic [63:0] memoryDataStrapPins,
    input wire logic terminalCountStrap,
    input wire logic [2:0] encodedDmaAckStrap,
    // I/O port access
    input wire logic [15:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWriteData,
    output logic [7:0] ioReadData,
    // Decoded settings
    output logic strapsValid,
    output logic [1:0] pciPllRange,
    output logic pciPllRangeReserved,
    output logic isaEnable,
    output logic pcmciaEnable,
    output logic localBusEnable,
    output logic memHostSync,
    output logic [2:0] pciClockDivisor,
    output logic bootDevice16,
    output logic firstSerialPortEnable,
    output logic secondSerialPortEnable,
    output logic keyboardMouseEnable,
    output logic parallelPortEnable,
    output logic [2:0] hostPllSpeed,
    output logic [1:0] cpuClockMult,
    output logic [3:0] hardwareStraps,
    // Clock pad controls
    output logic hostClockDriveEnable,
    output logic memoryClockOutputEnable,
    output logic dotClockDriveEnable
);
    strap_if st ();

    logic [7:0] index_q;
    logic [7:0] rdata_q;
    logic [1:0] busMode;

    strap_sampler u_sampler (
        .mclk(mclk),
        .reset_n(reset_n),
        .memoryDataStrapPins(memoryDataStrapPins),
        .terminalCountStrap(terminalCountStrap),
        .encodedDmaAckStrap(encodedDmaAckStrap),
        .st(st)
    );

    // Index port holds the selected register.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            index_q <= 8'h00;
        end else if (ioWrite && ioAddr == strap_pkg::INDEX_PORT) begin
            index_q <= ioWriteData;
        end
    end

    wire logic dataWr = ioWrite && ioAddr == strap_pkg::DATA_PORT;

    // Only bit 4 of bank two accepts writes; all other writes are dropped.
    assign st.dotDirWr = dataWr && index_q == strap_pkg::IDX_BANK_TWO; // see (RQ2) (RQ15)
    assign st.dotDirVal = ioWriteData[strap_pkg::B2_DOT_DIR];

    // Read data registered; unmapped indices read zero.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (ioRead) begin
            rdata_q <= 8'h00;
            if (ioAddr == strap_pkg::INDEX_PORT) begin
                rdata_q <= index_q;
            end else if (ioAddr == strap_pkg::DATA_PORT) begin
                case (index_q)
                    strap_pkg::IDX_BANK_ZERO: begin
                        rdata_q <= st.bankZero;
                    end
                    strap_pkg::IDX_BANK_ONE: begin
                        rdata_q <= st.bankOne;
                    end
                    strap_pkg::IDX_BANK_TWO: begin
                        rdata_q <= st.bankTwo;
                    end
                    strap_pkg::IDX_HOST_PLL: begin
                        rdata_q <= st.hostPll;
                    end
                    default: begin
                        rdata_q <= 8'h00;
                    end
                endcase
            end
        end
    end
    assign ioReadData = rdata_q;

    assign busMode = st.bankZero[5:4];

    // Decoded settings; clock controls held inactive before capture.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strapsValid <= 1'b0;
            pciPllRange <= 2'h0;
            pciPllRangeReserved <= 1'b0;
            isaEnable <= 1'b0;
            pcmciaEnable <= 1'b0;
            localBusEnable <= 1'b0;
            memHostSync <= 1'b0;
            pciClockDivisor <= 3'h4;
            bootDevice16 <= 1'b0;
            firstSerialPortEnable <= 1'b0;
            secondSerialPortEnable <= 1'b0;
            keyboardMouseEnable <= 1'b0;
            parallelPortEnable <= 1'b0;
            hostPllSpeed <= 3'h0;
            cpuClockMult <= 2'h0;
            hardwareStraps <= 4'h0;
            hostClockDriveEnable <= 1'b0;
            memoryClockOutputEnable <= 1'b0;
            dotClockDriveEnable <= 1'b0;
        end else if (st.captured) begin // see (RQ17)
            strapsValid <= 1'b1;
            pciPllRange <= st.bankZero[7:6]; // see (RQ3)
            pciPllRangeReserved <= st.bankZero[7]; // see (RQ3)
            isaEnable <= busMode == strap_pkg::BUS_ISA; // see (RQ4)
            pcmciaEnable <= busMode == strap_pkg::BUS_PCMCIA; // see (RQ4)
            localBusEnable <= busMode == strap_pkg::BUS_LOCAL; // see (RQ4)
            memHostSync <= st.bankZero[2]; // see (RQ5)
            pciClockDivisor <= strap_pkg::pciDivisor(st.bankZero[1:0]); // see (RQ6)
            bootDevice16 <= st.bankOne[0]; // see (RQ7)
            secondSerialPortEnable <= st.bankTwo[0]; // see (RQ8)
            firstSerialPortEnable <= st.bankTwo[1]; // see (RQ9)
            keyboardMouseEnable <= st.bankTwo[6]; // see (RQ10)
            parallelPortEnable <= st.bankTwo[7]; // see (RQ11)
            hostPllSpeed <= st.hostPll[5:3];
            cpuClockMult <= st.bankOne[7:6];
            hardwareStraps <= st.hwStraps; // see (RQ12)
            hostClockDriveEnable <= st.bankTwo[2]; // see (RQ13)
            memoryClockOutputEnable <= st.bankTwo[3]; // see (RQ14)
            dotClockDriveEnable <= st.bankTwo[strap_pkg::B2_DOT_DIR];
        end
    end

    property p_onebus;
        @(posedge mclk) disable iff (!reset_n)
        strapsValid |-> ($countones({isaEnable, pcmciaEnable, localBusEnable}) <= 1);
    endproperty
    a_onebus: assert property (p_onebus) else $error("More than one bus enabled."); // see (RQ4)

    property p_isa;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[5:4] == 2'h0 |=> isaEnable;
    endproperty
    a_isa: assert property (p_isa) else $error("ISA mode not enabled."); // see (RQ4)

    property p_div;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && !st.bankZero[1] |=> pciClockDivisor == 3'h4;
    endproperty
    a_div: assert property (p_div) else $error("PCI divisor not four."); // see (RQ6)

    property p_div2;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[1:0] == 2'h3 |=> pciClockDivisor == 3'h2;
    endproperty
    a_div2: assert property (p_div2) else $error("PCI divisor not two."); // see (RQ6)

    property p_ro;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && dataWr && index_q == strap_pkg::IDX_BANK_ZERO |=> $stable(st.bankZero);
    endproperty
    a_ro: assert property (p_ro) else $error("Bank zero changed by write."); // see (RQ2)

    property p_dotwr;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.dotDirWr |=> st.bankTwo[4] == $past(ioWriteData[4]);
    endproperty
    a_dotwr: assert property (p_dotwr) else $error("Dot direction write lost."); // see (RQ15)

    property p_rsv;
        @(posedge mclk) disable iff (!reset_n)
        st.bankZero[3] == 1'b0 && st.bankOne[5:1] == 5'h00 && st.bankTwo[5] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("Reserved bit set."); // see (RQ16)

    property p_clkhold;
        @(posedge mclk) disable iff (!reset_n)
        !strapsValid |-> !hostClockDriveEnable && !memoryClockOutputEnable;
    endproperty
    a_clkhold: assert property (p_clkhold) else $error("Clock pad on early."); // see (RQ17)

    property p_uart;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> firstSerialPortEnable == $past(st.bankTwo[1])
            && secondSerialPortEnable == $past(st.bankTwo[0]);
    endproperty
    a_uart: assert property (p_uart) else $error("Serial enable mismatch."); // see (RQ8) (RQ9)

    property p_range;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> pciPllRange == $past(st.bankZero[7:6])
            && pciPllRangeReserved == $past(st.bankZero[7]);
    endproperty
    a_range: assert property (p_range) else $error("PLL range mismatch."); // see (RQ3)

    property p_pcmcia;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[5:4] == 2'h1
            |=> pcmciaEnable && !isaEnable && !localBusEnable;
    endproperty
    a_pcmcia: assert property (p_pcmcia) else $error("PCMCIA mode wrong."); // see (RQ4)

    property p_local;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[5:4] == 2'h2 |=> localBusEnable && !isaEnable;
    endproperty
    a_local: assert property (p_local) else $error("Local bus mode wrong."); // see (RQ4)

    property p_nobus;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[5:4] == 2'h3
            |=> !isaEnable && !pcmciaEnable && !localBusEnable;
    endproperty
    a_nobus: assert property (p_nobus) else $error("Reserved mode enabled a bus."); // see (RQ4)

    property p_sync;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> memHostSync == $past(st.bankZero[2]);
    endproperty
    a_sync: assert property (p_sync) else $error("Sync strap mismatch."); // see (RQ5)

    property p_div3;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && st.bankZero[1:0] == 2'h2 |=> pciClockDivisor == 3'h3;
    endproperty
    a_div3: assert property (p_div3) else $error("PCI divisor not three."); // see (RQ6)

    property p_boot;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> bootDevice16 == $past(st.bankOne[0]);
    endproperty
    a_boot: assert property (p_boot) else $error("Boot width mismatch."); // see (RQ7)

    property p_periph;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> keyboardMouseEnable == $past(st.bankTwo[6])
            && parallelPortEnable == $past(st.bankTwo[7]);
    endproperty
    a_periph: assert property (p_periph) else $error("Enable mismatch."); // see (RQ10) (RQ11)

    property p_hw;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> hardwareStraps == $past(st.hwStraps);
    endproperty
    a_hw: assert property (p_hw) else $error("Hardware straps mismatch."); // see (RQ12)

    property p_clkpad;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> hostClockDriveEnable == $past(st.bankTwo[2])
            && memoryClockOutputEnable == $past(st.bankTwo[3]);
    endproperty
    a_clkpad: assert property (p_clkpad) else $error("Pad mismatch."); // see (RQ13) (RQ14)

    property p_b2hold;
        @(posedge mclk) disable iff (!reset_n)
        st.captured && !st.dotDirWr |=> $stable(st.bankTwo);
    endproperty
    a_b2hold: assert property (p_b2hold) else $error("Bank two changed."); // see (RQ15)

    property p_hpllrsv;
        @(posedge mclk) disable iff (!reset_n)
        st.hostPll[7:6] == 2'h0 && st.hostPll[2:0] == 3'h0;
    endproperty
    a_hpllrsv: assert property (p_hpllrsv) else $error("PLL reserved bit set."); // see (RQ16)

    property p_dotclk;
        @(posedge mclk) disable iff (!reset_n)
        st.captured |=> dotClockDriveEnable == $past(st.bankTwo[4]);
    endproperty
    a_dotclk: assert property (p_dotclk) else $error("Dot drive mismatch."); // see (RQ15)

    property p_early;
        @(posedge mclk) disable iff (!reset_n)
        !st.captured |=> !strapsValid && pciClockDivisor == 3'h4;
    endproperty
    a_early: assert property (p_early) else $error("Settings valid early."); // see (RQ17)
endmodule : strap_option_capture
`default_nettype wire

//--- bench/strap_board.sv
// Purpose: Board model holding the strap nets with pull resistors.
// Assumes: Every strap net is fitted with exactly one pull resistor.
// Notes: Levels are chosen by the bench per boot and inverted once after capture to check the hold.
`timescale 1ns/10ps
`default_nettype none
module strap_board (
    // Resistor levels fitted for this boot
    input wire logic [63:0] fitted,
    input wire logic [3:0] fittedHw,
    // Strap nets seen by the device
    output logic [63:0] memoryDataStrapPins,
    output logic terminalCountStrap,
    output logic [2:0] encodedDmaAckStrap
);
    // A resistor always gives a firm level, so the nets are never left floating.
    assign memoryDataStrapPins = fitted;
    assign {terminalCountStrap, encodedDmaAckStrap} = fittedHw;
endmodule : strap_board
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the strap option capture block.
// Assumes: Straps are steady from reset release until capture.
// Notes: Corner patterns first, then random straps from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic [63:0] fitted = 64'h0;
    logic [3:0] fittedHw = 4'hF;
    logic [63:0] memoryDataStrapPins;
    logic terminalCountStrap;
    logic [2:0] encodedDmaAckStrap;
    logic [15:0] ioAddr = 16'h0000;
    logic ioWrite = 1'h0;
    logic ioRead = 1'h0;
    logic [7:0] ioWriteData = 8'h00;
    logic [7:0] ioReadData;
    logic strapsValid, pciPllRangeReserved, isaEnable, pcmciaEnable, localBusEnable;
    logic memHostSync, bootDevice16, firstSerialPortEnable, secondSerialPortEnable;
    logic keyboardMouseEnable, parallelPortEnable, hostClockDriveEnable;
    logic memoryClockOutputEnable, dotClockDriveEnable;
    logic [1:0] pciPllRange, cpuClockMult;
    logic [2:0] pciClockDivisor, hostPllSpeed;
    logic [3:0] hardwareStraps;
    int n_mismatch = 0;
    int n_checks = 0;

    always #10 mclk = ~mclk;

    strap_board strap_board_i (.fitted(fitted), .fittedHw(fittedHw),
        .memoryDataStrapPins(memoryDataStrapPins), .terminalCountStrap(terminalCountStrap),
        .encodedDmaAckStrap(encodedDmaAckStrap));

    strap_option_capture strap_option_capture_i (.mclk(mclk), .reset_n(reset_n),
        .memoryDataStrapPins(memoryDataStrapPins), .terminalCountStrap(terminalCountStrap),
        .encodedDmaAckStrap(encodedDmaAckStrap), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWriteData(ioWriteData), .ioReadData(ioReadData),
        .strapsValid(strapsValid), .pciPllRange(pciPllRange),
        .pciPllRangeReserved(pciPllRangeReserved), .isaEnable(isaEnable),
        .pcmciaEnable(pcmciaEnable), .localBusEnable(localBusEnable),
        .memHostSync(memHostSync), .pciClockDivisor(pciClockDivisor),
        .bootDevice16(bootDevice16), .firstSerialPortEnable(firstSerialPortEnable),
        .secondSerialPortEnable(secondSerialPortEnable),
        .keyboardMouseEnable(keyboardMouseEnable), .parallelPortEnable(parallelPortEnable),
        .hostPllSpeed(hostPllSpeed), .cpuClockMult(cpuClockMult),
        .hardwareStraps(hardwareStraps), .hostClockDriveEnable(hostClockDriveEnable),
        .memoryClockOutputEnable(memoryClockOutputEnable),
        .dotClockDriveEnable(dotClockDriveEnable));

    function automatic logic [7:0] expReg(input logic [7:0] idx, input logic [63:0] p);
        case (idx)
            strap_pkg::IDX_BANK_ZERO: return {p[7], p[6], p[9], p[8], 1'h0, p[5], p[4], p[17]};
            strap_pkg::IDX_BANK_ONE: return {p[40], p[14], 5'h00, p[36]};
            strap_pkg::IDX_BANK_TWO: return {p[53], p[52], 1'h0, p[20], p[19], p[18],
                p[51], p[50]};
            strap_pkg::IDX_HOST_PLL: return {2'h0, p[26], p[25], p[24], 3'h0};
            default: return 8'h00;
        endcase
    endfunction : expReg

    function automatic logic [7:0] expDiv(input logic [63:0] p);
        return p[4] ? (p[17] ? 8'h02 : 8'h03) : 8'h04;
    endfunction : expDiv

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic ioWr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge mclk);
        ioAddr <= addr;
        ioWriteData <= data;
        ioWrite <= 1'h1;
        @(posedge mclk);
        ioWrite <= 1'h0;
    endtask : ioWr

    task automatic readReg(input logic [7:0] idx, output logic [7:0] rd);
        ioWr(strap_pkg::INDEX_PORT, idx);
        @(posedge mclk);
        ioAddr <= strap_pkg::DATA_PORT;
        ioRead <= 1'h1;
        @(posedge mclk);
        ioRead <= 1'h0;
        #1;
        rd = ioReadData;
    endtask : readReg

    task automatic runCase(input logic [63:0] p, input logic [3:0] hw);
        int n;
        logic [7:0] rd;
        logic [7:0] idx;
        @(posedge mclk);
        fitted <= p;
        fittedHw <= hw;
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        @(posedge mclk);
        #1;
        check("earlyValid", {7'h0, strapsValid}, 8'h00);
        check("earlyDivisor", {5'h0, pciClockDivisor}, 8'h04);
        check("earlyHostDrive", {7'h0, hostClockDriveEnable}, 8'h00);
        n = 0;
        while (strapsValid !== 1'h1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("valid", {7'h0, strapsValid}, 8'h01);
        check("pllRange", {5'h0, pciPllRangeReserved, pciPllRange},
            {5'h0, p[7], p[7:6]});
        check("busEnables", {5'h0, isaEnable, pcmciaEnable, localBusEnable},
            {5'h0, p[9:8] == 2'h0, p[9:8] == 2'h1, p[9:8] == 2'h2});
        check("memHostSync", {7'h0, memHostSync}, {7'h0, p[5]});
        check("divisor", {5'h0, pciClockDivisor}, expDiv(p));
        check("bootWidth", {7'h0, bootDevice16}, {7'h0, p[36]});
        check("serialTwo", {7'h0, secondSerialPortEnable}, {7'h0, p[50]});
        check("serialOne", {7'h0, firstSerialPortEnable}, {7'h0, p[51]});
        check("kbdMouse", {7'h0, keyboardMouseEnable}, {7'h0, p[52]});
        check("parallel", {7'h0, parallelPortEnable}, {7'h0, p[53]});
        check("hwStraps", {4'h0, hardwareStraps}, {4'h0, hw});
        check("hostDrive", {7'h0, hostClockDriveEnable}, {7'h0, p[18]});
        check("memClockOut", {7'h0, memoryClockOutputEnable}, {7'h0, p[19]});
        check("dotDrive", {7'h0, dotClockDriveEnable}, {7'h0, p[20]});
        check("pllSpeed", {5'h0, hostPllSpeed}, {5'h0, p[26:24]});
        check("cpuMult", {6'h0, cpuClockMult}, {6'h0, p[40], p[14]});
        for (int k = 0; k < 8; k++) begin
            idx = 8'h48 + 8'(k);
            readReg(idx, rd);
            check("regRead", rd, expReg(idx, p));
        end
        readReg(strap_pkg::IDX_HOST_PLL, rd);
        check("regPll", rd, expReg(strap_pkg::IDX_HOST_PLL, p));
        for (int k = 0; k < 3; k++) begin
            idx = (k == 2) ? strap_pkg::IDX_HOST_PLL : 8'h4A + 8'(k);
            ioWr(strap_pkg::INDEX_PORT, idx);
            ioWr(strap_pkg::DATA_PORT, ~expReg(idx, p));
            readReg(idx, rd);
            check("roWrite", rd, expReg(idx, p));
        end
        ioWr(strap_pkg::INDEX_PORT, strap_pkg::IDX_BANK_TWO);
        ioWr(strap_pkg::DATA_PORT, ~expReg(strap_pkg::IDX_BANK_TWO, p));
        readReg(strap_pkg::IDX_BANK_TWO, rd);
        check("bankTwoWrite", rd, expReg(strap_pkg::IDX_BANK_TWO, p) ^ 8'h10);
        check("dotDriveWritten", {7'h0, dotClockDriveEnable}, {7'h0, ~p[20]});
        @(posedge mclk);
        ioAddr <= strap_pkg::INDEX_PORT;
        ioRead <= 1'h1;
        @(posedge mclk);
        ioRead <= 1'h0;
        #1;
        check("indexRead", ioReadData, strap_pkg::IDX_BANK_TWO);
        fitted <= ~p;
        fittedHw <= ~hw;
        repeat (8) @(posedge mclk);
        readReg(strap_pkg::IDX_BANK_ZERO, rd);
        check("heldBank", rd, expReg(strap_pkg::IDX_BANK_ZERO, p));
        check("heldDivisor", {5'h0, pciClockDivisor}, expDiv(p));
        check("heldHw", {4'h0, hardwareStraps}, {4'h0, hw});
    endtask : runCase

    initial begin
        logic [63:0] p;
        void'($urandom(32'h93A2D2F0));
        for (int i = 0; i < 10; i++) begin
            p = {$urandom, $urandom};
            if (i == 0) begin
                p = 64'h0;
            end else if (i == 1) begin
                p = ~64'h0;
            end else begin
                p[9:8] = i[1:0];
                p[4] = i[2];
                p[17] = i[0];
            end
            runCase(p, 4'($urandom));
        end
        conclude();
    end

    initial begin
        repeat (6000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
